// ### rtl/bmx_exec.sv
/*
  Execution block for the bit, shift, flag, data-transfer and core-control groups.
  Holds the working registers, the status register and the stack pointer.
  Assumes data memory and program memory answer as described at their ports,
  and that the I/O space is read combinationally.
*/
// How it works
// RL1: Set or clear I/O bit, two cycles.
// RL2: Logical left shift, zero in, one cycle.
// RL3: Logical right shift, zero in, one cycle.
// RL4: Rotates pass through carry, one cycle.
// RL5: Arithmetic right shift keeps sign bit.
// RL6: Bit to T and T to bit.
// RL7: Each flag set or cleared alone.
// RL8: Post-increment indirect loads, two cycles.
// RL9: Pre-decrement loads read decremented address.
// RL10: Offset loads through Y or Z only.
// RL11: Direct load, two cycles, no flags.
// RL12: Indirect stores with all pointer updates.
// RL13: Offset stores leave pointer unchanged.
// RL14: Direct store, two cycles, no flags.
// RL15: Program memory read, three cycles.
// RL16: Push and pop, two cycles each.
// RL17: Sleep and watchdog restart, one cycle.
// RL18: Break serves debug, waits for release.
// RL19: Register copies take one cycle.
// RL20: Program memory write waits for unit.
`timescale 1ns/1ps

module bmx_exec #(
  parameter int unsigned NUM_REGS = 32
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_instr_valid,
  input wire bmx_pkg::bmx_instr_type i_instr,
  output logic o_ready,
  output bmx_pkg::bmx_dmem_req_type o_dmem,
  input wire logic [7:0] i_dmem_rdata,
  output logic [5:0] o_io_raddr,
  input wire logic [7:0] i_io_rdata,
  output bmx_pkg::bmx_io_wr_type o_io_wr,
  output bmx_pkg::bmx_pmem_req_type o_pmem,
  input wire logic [7:0] i_pmem_rdata,
  output bmx_pkg::bmx_spm_req_type o_spm,
  input wire logic i_spm_done,
  output logic o_sleep_req,
  output logic o_wdr_req,
  output logic o_break_req,
  input wire logic i_break_release,
  output logic o_bad_op,
  output logic [7:0] o_status,
  output logic [15:0] o_sp,
  input wire logic [4:0] i_peek_idx,
  output logic [7:0] o_peek_data
);

  // The pointer pairs sit at the top of a file of exactly 32 registers.
  if (NUM_REGS != 32) begin : g_bad_regs
    $error("NUM_REGS must be 32");
  end

  // Control states and the source of a delayed register write.
  typedef enum logic [1:0] {ST_READY, ST_WAIT, ST_SPM, ST_BRK} bmx_state_type;
  typedef enum logic [1:0] {SRC_NONE, SRC_DMEM, SRC_PMEM} bmx_src_type;

  logic [7:0] gpr [NUM_REGS];  // Working registers.
  logic [7:0] status;  // Status flags.
  logic [15:0] sp;  // Stack pointer.
  bmx_state_type state;  // Control state.
  logic [1:0] cnt;  // Busy cycles left.
  logic [4:0] lat_rd;  // Destination of a delayed load.
  bmx_src_type lat_src;  // Where the delayed load comes from.

  // Next values computed by the combinational process.
  bmx_state_type next_state;
  bmx_src_type next_lat_src;
  logic [7:0] next_status;
  logic [15:0] next_sp;
  logic [1:0] next_cnt;
  logic [4:0] next_lat_rd;
  bmx_pkg::bmx_dmem_req_type next_dmem;
  bmx_pkg::bmx_io_wr_type next_io_wr;
  bmx_pkg::bmx_pmem_req_type next_pmem;
  bmx_pkg::bmx_spm_req_type next_spm;
  logic next_sleep;
  logic next_wdr;
  logic next_brk;
  logic next_bad;

  // Two register write ports; the second serves pairs.
  logic wa_en;
  logic [4:0] wa_idx;
  logic [7:0] wa_dat;
  logic wb_en;
  logic [4:0] wb_idx;
  logic [7:0] wb_dat;

  // Operand and address decoding.
  wire bmx_pkg::bmx_op_type op = i_instr.op;
  wire logic acc = i_ce & i_instr_valid & o_ready;
  wire logic [7:0] rd_val = gpr[i_instr.rd];
  wire logic [7:0] rr_val = gpr[i_instr.rr];
  wire logic [7:0] bit_mask = 8'h01 << i_instr.bitn;
  wire logic [4:0] ptr_lo = (i_instr.ptr == bmx_pkg::PTR_Y) ? bmx_pkg::REG_Y_LO :
                            (i_instr.ptr == bmx_pkg::PTR_Z) ? bmx_pkg::REG_Z_LO :
                            bmx_pkg::REG_X_LO;
  wire logic [4:0] ptr_hi = ptr_lo | 5'h01;
  wire logic [15:0] ptr_val = {gpr[ptr_hi], gpr[ptr_lo]};
  wire logic [15:0] z_val = {gpr[bmx_pkg::REG_Z_LO | 5'h01], gpr[bmx_pkg::REG_Z_LO]};
  wire logic [15:0] ptr_inc = ptr_val + 16'h0001;
  wire logic [15:0] ptr_dec = ptr_val - 16'h0001;
  wire logic [15:0] disp = {10'h000, i_instr.k[5:0]};
  wire logic is_post = i_instr.mode == bmx_pkg::MODE_POST;
  wire logic is_pre = i_instr.mode == bmx_pkg::MODE_PRE;
  wire logic is_disp = i_instr.mode == bmx_pkg::MODE_DISP;
  // Pre-decrement addresses the decremented pointer; displacement leaves it alone.
  wire logic [15:0] eff_addr = is_pre ? ptr_dec : is_disp ? ptr_val + disp : ptr_val;  // [RL9] [RL10]
  wire logic [15:0] ptr_new = is_post ? ptr_inc : ptr_dec;
  wire logic ptr_upd = is_post | is_pre;
  // Displacement is only offered through Y and Z, and pair code 3 names nothing.
  wire logic ptr_bad = (i_instr.ptr == 2'h3) |
                       (is_disp & (i_instr.ptr == bmx_pkg::PTR_X));  // [RL10]
  wire logic [4:0] pair_d = {i_instr.rd[4:1], 1'b0};
  wire logic [4:0] pair_s = {i_instr.rr[4:1], 1'b0};
  wire logic [15:0] sp_inc = sp + 16'h0001;
  wire logic [15:0] sp_dec = sp - 16'h0001;

  // Shift unit: result and the bit shifted out.
  logic [7:0] sh_res;
  logic sh_c;
  always_comb begin
    case (op)
      bmx_pkg::OP_LSL: begin
        sh_res = {rd_val[6:0], 1'b0};  // [RL2]
        sh_c = rd_val[7];
      end
      bmx_pkg::OP_LSR: begin
        sh_res = {1'b0, rd_val[7:1]};  // [RL3]
        sh_c = rd_val[0];
      end
      bmx_pkg::OP_ROL: begin
        sh_res = {rd_val[6:0], status[bmx_pkg::FLG_C]};  // [RL4]
        sh_c = rd_val[7];
      end
      bmx_pkg::OP_ROR: begin
        sh_res = {status[bmx_pkg::FLG_C], rd_val[7:1]};  // [RL4]
        sh_c = rd_val[0];
      end
      default: begin
        sh_res = {rd_val[7], rd_val[7:1]};  // [RL5]
        sh_c = rd_val[0];
      end
    endcase
  end

  // Decode and sequencing: one instruction taken per ready cycle.
  always_comb begin
    next_state = state;
    next_lat_src = lat_src;
    next_status = status;
    next_sp = sp;
    next_cnt = cnt;
    next_lat_rd = lat_rd;
    next_dmem = '0;
    next_io_wr = '0;
    next_pmem = '0;
    next_spm = o_spm;
    next_spm.req = 1'b0;
    next_sleep = 1'b0;
    next_wdr = 1'b0;
    next_brk = 1'b0;
    next_bad = 1'b0;
    wa_en = 1'b0;
    wa_idx = i_instr.rd;
    wa_dat = 8'h00;
    wb_en = 1'b0;
    wb_idx = ptr_hi;
    wb_dat = 8'h00;
    case (state)
      ST_READY: begin
        if (i_instr_valid) begin
          case (op)
            bmx_pkg::OP_NOP: begin
              next_bad = 1'b0;
            end
            // Read-modify-write of one I/O bit; the write goes out next cycle.
            bmx_pkg::OP_SETIO, bmx_pkg::OP_CLRIO: begin
              next_io_wr.we = 1'b1;
              next_io_wr.addr = i_instr.k[5:0];
              next_io_wr.wdata = (op == bmx_pkg::OP_SETIO) ? (i_io_rdata | bit_mask) :
                                 (i_io_rdata & ~bit_mask);  // [RL1]
              next_lat_src = SRC_NONE;
              next_cnt = bmx_pkg::CYC_BIT_IO - 2'h1;  // [RL1]
              next_state = ST_WAIT;
            end
            // Shifts and rotates write Z, C, N and V with V = N xor C.
            bmx_pkg::OP_LSL, bmx_pkg::OP_LSR, bmx_pkg::OP_ROL, bmx_pkg::OP_ROR,
            bmx_pkg::OP_ASR: begin
              wa_en = 1'b1;
              wa_dat = sh_res;
              next_status[bmx_pkg::FLG_C] = sh_c;  // [RL2] [RL3] [RL4] [RL5]
              next_status[bmx_pkg::FLG_Z] = sh_res == 8'h00;
              next_status[bmx_pkg::FLG_N] = sh_res[7];
              next_status[bmx_pkg::FLG_V] = sh_res[7] ^ sh_c;
            end
            bmx_pkg::OP_SWAP: begin
              wa_en = 1'b1;
              wa_dat = {rd_val[3:0], rd_val[7:4]};  // [RL19]
            end
            // Indexed flag forms; the named forms use fixed indices.
            bmx_pkg::OP_FSET: begin
              next_status[i_instr.bitn] = 1'b1;  // [RL7]
            end
            bmx_pkg::OP_FCLR: begin
              next_status[i_instr.bitn] = 1'b0;  // [RL7]
            end
            bmx_pkg::OP_BST: begin
              next_status[bmx_pkg::FLG_T] = rr_val[i_instr.bitn];  // [RL6]
            end
            bmx_pkg::OP_BLD: begin
              wa_en = 1'b1;
              wa_dat = status[bmx_pkg::FLG_T] ? (rd_val | bit_mask) : (rd_val & ~bit_mask);  // [RL6]
            end
            bmx_pkg::OP_MOV: begin
              wa_en = 1'b1;
              wa_dat = rr_val;  // [RL19]
            end
            // Pair copy uses the even register of each operand.
            bmx_pkg::OP_COPY_REGISTER_PAIR: begin
              wa_en = 1'b1;
              wa_idx = pair_d;
              wa_dat = gpr[pair_s];  // [RL19]
              wb_en = 1'b1;
              wb_idx = pair_d | 5'h01;
              wb_dat = gpr[pair_s | 5'h01];
            end
            bmx_pkg::OP_LDI: begin
              wa_en = 1'b1;
              wa_dat = i_instr.k[7:0];  // [RL19]
            end
            bmx_pkg::OP_IN: begin
              wa_en = 1'b1;
              wa_dat = i_io_rdata;  // [RL19]
            end
            bmx_pkg::OP_OUT: begin
              next_io_wr.we = 1'b1;
              next_io_wr.addr = i_instr.k[5:0];
              next_io_wr.wdata = rr_val;  // [RL19]
            end
            // Indirect and direct data memory accesses, all two cycles.
            bmx_pkg::OP_LD_IND, bmx_pkg::OP_ST_IND, bmx_pkg::OP_LD_DIR,
            bmx_pkg::OP_ST_DIR: begin
              if (ptr_bad && (op == bmx_pkg::OP_LD_IND || op == bmx_pkg::OP_ST_IND)) begin
                next_bad = 1'b1;
              end else begin
                next_dmem.en = 1'b1;
                next_dmem.we = (op == bmx_pkg::OP_ST_IND) || (op == bmx_pkg::OP_ST_DIR);  // [RL12]
                next_dmem.addr = (op == bmx_pkg::OP_LD_DIR || op == bmx_pkg::OP_ST_DIR) ?
                                 i_instr.k : eff_addr;  // [RL11] [RL14]
                next_dmem.wdata = rr_val;  // [RL12] [RL13] [RL14]
                wa_en = ptr_upd && (op == bmx_pkg::OP_LD_IND || op == bmx_pkg::OP_ST_IND);
                wa_idx = ptr_lo;
                wa_dat = ptr_new[7:0];  // [RL8] [RL9] [RL12]
                wb_en = wa_en;
                wb_dat = ptr_new[15:8];
                next_lat_rd = i_instr.rd;
                next_lat_src = next_dmem.we ? SRC_NONE : SRC_DMEM;
                next_cnt = bmx_pkg::CYC_MEM - 2'h1;  // [RL8] [RL11] [RL14]
                next_state = ST_WAIT;
              end
            end
            // Byte read from program memory at Z, optional Z increment.
            bmx_pkg::OP_PM_READ: begin
              next_pmem.en = 1'b1;
              next_pmem.addr = z_val;  // [RL15]
              wa_en = is_post;
              wa_idx = bmx_pkg::REG_Z_LO;
              wa_dat = z_val[7:0] + 8'h01;
              wb_en = is_post;
              wb_idx = bmx_pkg::REG_Z_LO | 5'h01;
              wb_dat = z_val[15:8] + {7'h00, &z_val[7:0]};
              next_lat_rd = i_instr.rd;
              next_lat_src = SRC_PMEM;
              next_cnt = bmx_pkg::CYC_PMEM - 2'h1;  // [RL15]
              next_state = ST_WAIT;
            end
            bmx_pkg::OP_PM_WRITE: begin
              next_spm.req = 1'b1;
              next_spm.addr = z_val;
              next_spm.word = {gpr[1], gpr[0]};  // [RL20]
              next_state = ST_SPM;
            end
            // Push writes then moves down; pop moves up then reads.
            bmx_pkg::OP_PUSH, bmx_pkg::OP_POP: begin
              next_dmem.en = 1'b1;
              next_dmem.we = op == bmx_pkg::OP_PUSH;
              next_dmem.addr = (op == bmx_pkg::OP_PUSH) ? sp : sp_inc;  // [RL16]
              next_dmem.wdata = rr_val;
              next_sp = (op == bmx_pkg::OP_PUSH) ? sp_dec : sp_inc;  // [RL16]
              next_lat_rd = i_instr.rd;
              next_lat_src = (op == bmx_pkg::OP_PUSH) ? SRC_NONE : SRC_DMEM;
              next_cnt = bmx_pkg::CYC_MEM - 2'h1;  // [RL16]
              next_state = ST_WAIT;
            end
            bmx_pkg::OP_SLEEP: begin
              next_sleep = 1'b1;  // [RL17]
            end
            bmx_pkg::OP_WDR: begin
              next_wdr = 1'b1;  // [RL17]
            end
            bmx_pkg::OP_BREAK: begin
              next_brk = 1'b1;  // [RL18]
              next_state = ST_BRK;
            end
            default: begin
              next_bad = 1'b1;
            end
          endcase
        end
      end
      // Last busy cycle captures the returned byte.
      ST_WAIT: begin
        if (cnt == 2'h1) begin
          wa_en = lat_src != SRC_NONE;
          wa_idx = lat_rd;
          wa_dat = (lat_src == SRC_PMEM) ? i_pmem_rdata : i_dmem_rdata;  // [RL8] [RL15]
          next_state = ST_READY;
        end else begin
          next_cnt = cnt - 2'h1;
        end
      end
      ST_SPM: begin
        if (i_spm_done) begin
          next_state = ST_READY;  // [RL20]
        end
      end
      ST_BRK: begin
        if (i_break_release) begin
          next_state = ST_READY;  // [RL18]
        end
      end
      default: begin
        next_state = ST_READY;
      end
    endcase
  end

  assign o_ready = state == ST_READY;
  assign o_io_raddr = i_instr.k[5:0];
  assign o_status = status;
  assign o_sp = sp;

  // Register file: each entry takes port A first, then port B.
  for (genvar gi = 0; gi < 32; gi++) begin : g_gpr
    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        gpr[gi] <= bmx_pkg::GPR_RST;
      end else if (i_ce && wa_en && wa_idx == 5'(gi)) begin
        gpr[gi] <= wa_dat;
      end else if (i_ce && wb_en && wb_idx == 5'(gi)) begin
        gpr[gi] <= wb_dat;
      end
    end
  end

  // Control state and status flags.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= ST_READY;
      status <= bmx_pkg::STATUS_RST;
      sp <= bmx_pkg::SP_RST;
      cnt <= 2'h0;
      lat_rd <= 5'h00;
      lat_src <= SRC_NONE;
    end else if (i_ce) begin
      state <= next_state;
      status <= next_status;
      sp <= next_sp;
      cnt <= next_cnt;
      lat_rd <= next_lat_rd;
      lat_src <= next_lat_src;
    end
  end

  // Registered requests and pulses toward the outside units.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_dmem <= '0;
      o_io_wr <= '0;
      o_pmem <= '0;
      o_spm <= '0;
      o_sleep_req <= 1'b0;
      o_wdr_req <= 1'b0;
      o_break_req <= 1'b0;
      o_bad_op <= 1'b0;
      o_peek_data <= 8'h00;
    end else if (i_ce) begin
      o_dmem <= next_dmem;
      o_io_wr <= next_io_wr;
      o_pmem <= next_pmem;
      o_spm <= next_spm;
      o_sleep_req <= next_sleep;
      o_wdr_req <= next_wdr;
      o_break_req <= next_brk;
      o_bad_op <= next_bad;
      o_peek_data <= gpr[i_peek_idx];
    end
  end

  // An I/O bit write appears next cycle, then the block is ready again.
  io_bit_a: assert property (@(posedge i_clk) disable iff (i_srst || !i_ce)  // [RL1]
    acc && op == bmx_pkg::OP_SETIO |=> o_io_wr.we && !o_ready &&
    o_io_wr.wdata == ($past(i_io_rdata) | $past(bit_mask)) && status == $past(status) ##1 o_ready)
    else $error("I/O bit set wrong");

  // A left shift carries out bit 7 and leaves V equal to N xor C.
  shift_flags_a: assert property (@(posedge i_clk) disable iff (i_srst || !i_ce)  // [RL2]
    acc && op == bmx_pkg::OP_LSL |=> status[bmx_pkg::FLG_C] == $past(rd_val[7]) &&
    status[bmx_pkg::FLG_V] == (status[bmx_pkg::FLG_N] ^ status[bmx_pkg::FLG_C]) && o_ready)
    else $error("left shift flags wrong");

  // A flag clear changes only the chosen flag.
  flag_only_a: assert property (@(posedge i_clk) disable iff (i_srst || !i_ce)  // [RL7]
    acc && op == bmx_pkg::OP_FCLR |=> status == ($past(status) & ~$past(bit_mask)))
    else $error("flag clear touched other flags");

  // Pre-decrement reads the decremented pointer, data lands one cycle later.
  predec_load_a: assert property (@(posedge i_clk) disable iff (i_srst || !i_ce)  // [RL9]
    acc && op == bmx_pkg::OP_LD_IND && is_pre && !ptr_bad |=>
    o_dmem.en && !o_dmem.we && o_dmem.addr == $past(ptr_dec) && !o_ready ##1 o_ready)
    else $error("pre-decrement load wrong");

  // A direct store writes the embedded address and leaves the flags alone.
  direct_store_a: assert property (@(posedge i_clk) disable iff (i_srst || !i_ce)  // [RL14]
    acc && op == bmx_pkg::OP_ST_DIR |=> o_dmem.we && o_dmem.addr == $past(i_instr.k) &&
    status == $past(status))
    else $error("direct store wrong");

  // Program memory reads hold the block busy for exactly two further cycles.
  pm_three_a: assert property (@(posedge i_clk) disable iff (i_srst || !i_ce)  // [RL15]
    acc && op == bmx_pkg::OP_PM_READ |=> o_pmem.en ##1 (!o_ready && !o_pmem.en) ##1 o_ready)
    else $error("program memory read timing wrong");

  // Push writes at the old stack pointer and moves it down by one.
  push_sp_a: assert property (@(posedge i_clk) disable iff (i_srst || !i_ce)  // [RL16]
    acc && op == bmx_pkg::OP_PUSH |=> o_sp == $past(sp) - 16'h0001 && o_dmem.addr == $past(sp))
    else $error("push stack pointer wrong");

  // Sleep request is a single pulse and the block stays ready.
  sleep_pulse_a: assert property (@(posedge i_clk) disable iff (i_srst || !i_ce)  // [RL17]
    acc && op == bmx_pkg::OP_SLEEP |=> o_sleep_req && o_ready ##1 !o_sleep_req)
    else $error("sleep request not one pulse");

endmodule  // bmx_exec

// ### rtl/bmx_pkg.sv
/*
  Shared types and constants for the bit, shift, flag, data-transfer and core-control
  execution block of the 8-bit core.
  Assumes a single core clock, and memories and the I/O space that sit outside the block.
*/
package bmx_pkg;

  // Operation codes of the executed instruction word (a local encoding).
  typedef enum logic [5:0] {
    OP_NOP      = 6'h00,
    OP_SETIO    = 6'h01,
    OP_CLRIO    = 6'h02,
    OP_LSL      = 6'h03,
    OP_LSR      = 6'h04,
    OP_ROL      = 6'h05,
    OP_ROR      = 6'h06,
    OP_ASR      = 6'h07,
    OP_SWAP     = 6'h08,
    OP_FSET     = 6'h09,
    OP_FCLR     = 6'h0A,
    OP_BST      = 6'h0B,
    OP_BLD      = 6'h0C,
    OP_MOV      = 6'h0D,
    OP_COPY_REGISTER_PAIR     = 6'h0E,
    OP_LDI      = 6'h0F,
    OP_LD_IND   = 6'h10,
    OP_LD_DIR   = 6'h11,
    OP_ST_IND   = 6'h12,
    OP_ST_DIR   = 6'h13,
    OP_PM_READ  = 6'h14,
    OP_PM_WRITE = 6'h15,
    OP_IN       = 6'h16,
    OP_OUT      = 6'h17,
    OP_PUSH     = 6'h18,
    OP_POP      = 6'h19,
    OP_SLEEP    = 6'h1A,
    OP_WDR      = 6'h1B,
    OP_BREAK    = 6'h1C
  } bmx_op_type;

  // One instruction as handed to the block.
  typedef struct packed {
    bmx_op_type op;    // Operation.
    logic [4:0] rd;    // Destination register.
    logic [4:0] rr;    // Source register.
    logic [1:0] ptr;   // Pointer pair select.
    logic [1:0] mode;  // Pointer addressing mode.
    logic [2:0] bitn;  // Bit or flag number.
    logic [15:0] k;    // Immediate, address, displacement or I/O address.
  } bmx_instr_type;

  // Data memory request.
  typedef struct packed {
    logic en;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } bmx_dmem_req_type;

  // I/O space write.
  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [7:0] wdata;
  } bmx_io_wr_type;

  // Program memory byte read request.
  typedef struct packed {
    logic en;
    logic [15:0] addr;
  } bmx_pmem_req_type;

  // Self-programming request.
  typedef struct packed {
    logic req;
    logic [15:0] addr;
    logic [15:0] word;
  } bmx_spm_req_type;

  // Flag positions in the status register.
  localparam logic [2:0] FLG_C = 3'h0;
  localparam logic [2:0] FLG_Z = 3'h1;
  localparam logic [2:0] FLG_N = 3'h2;
  localparam logic [2:0] FLG_V = 3'h3;
  localparam logic [2:0] FLG_S = 3'h4;
  localparam logic [2:0] FLG_H = 3'h5;
  localparam logic [2:0] FLG_T = 3'h6;
  localparam logic [2:0] FLG_I = 3'h7;

  // Pointer pair selects and addressing modes.
  localparam logic [1:0] PTR_X = 2'h0;
  localparam logic [1:0] PTR_Y = 2'h1;
  localparam logic [1:0] PTR_Z = 2'h2;
  localparam logic [1:0] MODE_PLAIN = 2'h0;
  localparam logic [1:0] MODE_POST = 2'h1;
  localparam logic [1:0] MODE_PRE = 2'h2;
  localparam logic [1:0] MODE_DISP = 2'h3;

  // Low register of each pointer pair.
  localparam logic [4:0] REG_X_LO = 5'h1A;
  localparam logic [4:0] REG_Y_LO = 5'h1C;
  localparam logic [4:0] REG_Z_LO = 5'h1E;

  // Values after reset.
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [15:0] SP_RST = 16'hFFFF;
  localparam logic [7:0] GPR_RST = 8'h00;

  // Cycle counts of the multi-cycle groups.
  localparam logic [1:0] CYC_BIT_IO = 2'h2;
  localparam logic [1:0] CYC_MEM = 2'h2;
  localparam logic [1:0] CYC_PMEM = 2'h3;

endpackage

// ### verification/bmx_exec_bench.sv
/*
  Self-checking bench for the execution block.
  Assumes the memory model answers for data, I/O and program memory.
*/
`timescale 1ns/1ps
module bmx_exec_bench;
  logic i_clk = 1'b0, i_srst = 1'b1, i_instr_valid = 1'b0;
  bmx_pkg::bmx_instr_type i_instr = '0;
  logic [4:0] i_peek_idx = 5'h00;
  logic o_ready, o_sleep_req, o_wdr_req, o_break_req, o_bad_op, spm_done;
  bmx_pkg::bmx_dmem_req_type o_dmem;
  bmx_pkg::bmx_io_wr_type o_io_wr;
  bmx_pkg::bmx_pmem_req_type o_pmem;
  bmx_pkg::bmx_spm_req_type o_spm;
  logic [7:0] dm_rd, io_rd, pm_rd, o_status, o_peek_data, pul;
  logic [5:0] o_io_raddr;
  logic [15:0] o_sp;
  int n_mismatch = 0, n_checks = 0, cyc;
  always #5 i_clk = ~i_clk;
  bmx_exec DUT (.i_clk(i_clk), .i_srst(i_srst), .i_ce(1'b1), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .o_ready(o_ready), .o_dmem(o_dmem), .i_dmem_rdata(dm_rd),
    .o_io_raddr(o_io_raddr), .i_io_rdata(io_rd), .o_io_wr(o_io_wr), .o_pmem(o_pmem),
    .i_pmem_rdata(pm_rd), .o_spm(o_spm), .i_spm_done(spm_done), .o_sleep_req(o_sleep_req),
    .o_wdr_req(o_wdr_req), .o_break_req(o_break_req), .i_break_release(1'b1),
    .o_bad_op(o_bad_op), .o_status(o_status), .o_sp(o_sp), .i_peek_idx(i_peek_idx),
    .o_peek_data(o_peek_data));
  bmx_mem_model mdl (.i_clk(i_clk), .i_dmem(o_dmem), .o_dmem_rdata(dm_rd),
    .i_io_raddr(o_io_raddr), .o_io_rdata(io_rd), .i_io_wr(o_io_wr), .i_pmem(o_pmem),
    .o_pmem_rdata(pm_rd), .i_spm(o_spm), .o_spm_done(spm_done));
  // Compares one result and counts it.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Issues one instruction, notes the pulses after it and counts its cycles.
  task automatic run(input bmx_pkg::bmx_op_type op, input logic [4:0] rd, input logic [4:0] rr,
      input logic [1:0] ptr, input logic [1:0] md, input logic [2:0] b, input logic [15:0] k);
    @(posedge i_clk);
    i_instr_valid <= 1'b1;
    i_instr <= '{op, rd, rr, ptr, md, b, k};
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    #1 pul = {o_bad_op, o_break_req, o_sleep_req, o_wdr_req, o_io_wr.we, o_dmem.en, o_pmem.en,
      o_spm.req};
    cyc = 1;
    while (o_ready !== 1'b1 && cyc < 50) begin
      @(posedge i_clk);
      #1 cyc++;
    end
  endtask
  // Reads a working register through the registered peek port.
  task automatic peek(input logic [4:0] idx, input logic [7:0] exp);
    @(posedge i_clk);
    i_peek_idx <= idx;
    repeat (2) @(posedge i_clk);
    #1 chk({8'h00, o_peek_data}, {8'h00, exp});
  endtask
  // Shifts and rotates with their flags.
  task automatic t_shift();
    run(bmx_pkg::OP_LDI, 16, 0, 0, 0, 0, 16'h0081);
    run(bmx_pkg::OP_LSL, 16, 0, 0, 0, 0, 0);
    chk(cyc, 1);
    chk(o_status, 16'h0009);
    run(bmx_pkg::OP_LSR, 16, 0, 0, 0, 0, 0);
    chk(o_status, 16'h0000);
    run(bmx_pkg::OP_FSET, 0, 0, 0, 0, bmx_pkg::FLG_C, 0);
    run(bmx_pkg::OP_ROL, 16, 0, 0, 0, 0, 0);
    peek(16, 8'h03);
    run(bmx_pkg::OP_ROR, 16, 0, 0, 0, 0, 0);
    chk(o_status, 16'h0009);
    run(bmx_pkg::OP_LDI, 16, 0, 0, 0, 0, 16'h0080);
    run(bmx_pkg::OP_ASR, 16, 0, 0, 0, 0, 0);
    chk(o_status, 16'h000c);
    peek(16, 8'hc0);
  endtask
  // Every flag set and cleared alone, then the transfer flag.
  task automatic t_flags();
    logic [7:0] m;
    for (int i = 0; i < 8; i++) run(bmx_pkg::OP_FCLR, 0, 0, 0, 0, 3'(i), 0);
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      run(bmx_pkg::OP_FSET, 0, 0, 0, 0, 3'(i), 0);
      m[i] = 1'b1;
      chk(o_status, {8'h00, m});
    end
    for (int i = 0; i < 8; i++) begin
      run(bmx_pkg::OP_FCLR, 0, 0, 0, 0, 3'(i), 0);
      m[i] = 1'b0;
      chk(o_status, {8'h00, m});
    end
    run(bmx_pkg::OP_LDI, 17, 0, 0, 0, 0, 16'h0020);
    run(bmx_pkg::OP_BST, 0, 17, 0, 0, 5, 0);
    chk(o_status, 16'h0040);
    run(bmx_pkg::OP_BLD, 18, 0, 0, 0, 3, 0);
    peek(18, 8'h08);
  endtask
  // Port write, then bit set and clear on it.
  task automatic t_io();
    run(bmx_pkg::OP_OUT, 0, 17, 0, 0, 0, 16'h0005);
    chk(cyc, 1);
    run(bmx_pkg::OP_SETIO, 0, 0, 0, 0, 0, 16'h0005);
    chk(cyc, 2);
    chk(mdl.io_mem[5], 16'h0021);
    run(bmx_pkg::OP_CLRIO, 0, 0, 0, 0, 5, 16'h0005);
    chk(mdl.io_mem[5], 16'h0001);
    chk(o_status, 16'h0040);
  endtask
  // Post-increment and offset pointer stores, a pre-decrement pointer load, a rejected X offset load, direct, stack, program memory.
  task automatic t_mem();
    run(bmx_pkg::OP_LDI, 28, 0, 0, 0, 0, 16'h0010);
    run(bmx_pkg::OP_LDI, 20, 0, 0, 0, 0, 16'h00a5);
    run(bmx_pkg::OP_ST_IND, 0, 20, bmx_pkg::PTR_Y, bmx_pkg::MODE_POST, 0, 0);
    chk(cyc, 2);
    chk(mdl.dmem[16], 16'h00a5);
    peek(28, 8'h11);
    run(bmx_pkg::OP_LD_IND, 21, 0, bmx_pkg::PTR_Y, bmx_pkg::MODE_PRE, 0, 0);
    chk(cyc, 2);
    peek(21, 8'ha5);
    run(bmx_pkg::OP_ST_IND, 0, 21, bmx_pkg::PTR_Y, bmx_pkg::MODE_DISP, 0, 16'h0003);
    chk(mdl.dmem[19], 16'h00a5);
    run(bmx_pkg::OP_LD_DIR, 22, 0, 0, 0, 0, 16'h0013);
    chk(cyc, 2);
    peek(22, 8'ha5);
    run(bmx_pkg::OP_ST_DIR, 0, 28, 0, 0, 0, 16'h0020);
    chk(mdl.dmem[32], 16'h0010);
    run(bmx_pkg::OP_LD_IND, 23, 0, bmx_pkg::PTR_X, bmx_pkg::MODE_DISP, 0, 0);
    chk(pul[7], 1);
    run(bmx_pkg::OP_PUSH, 0, 20, 0, 0, 0, 0);
    chk(o_sp, 16'hfffe);
    run(bmx_pkg::OP_POP, 24, 0, 0, 0, 0, 0);
    chk({o_sp[7:0], 8'(cyc)}, 16'hff02);
    peek(24, 8'ha5);
    run(bmx_pkg::OP_LDI, 30, 0, 0, 0, 0, 16'h0007);
    run(bmx_pkg::OP_PM_READ, 0, 0, 0, bmx_pkg::MODE_POST, 0, 0);
    chk(cyc, 3);
    peek(0, 8'h5d);
    peek(30, 8'h08);
  endtask
  // Copies, nibble exchange, core control and program write.
  task automatic t_ctrl();
    run(bmx_pkg::OP_SWAP, 24, 0, 0, 0, 0, 0);
    peek(24, 8'h5a);
    run(bmx_pkg::OP_COPY_REGISTER_PAIR, 2, 20, 0, 0, 0, 0);
    peek(3, 8'ha5);
    run(bmx_pkg::OP_SLEEP, 0, 0, 0, 0, 0, 0);
    chk({pul, 8'(cyc)}, 16'h2001);
    run(bmx_pkg::OP_WDR, 0, 0, 0, 0, 0, 0);
    chk({pul, 8'(cyc)}, 16'h1001);
    run(bmx_pkg::OP_BREAK, 0, 0, 0, 0, 0, 0);
    chk(pul[6], 1);
    run(bmx_pkg::OP_PM_WRITE, 0, 0, 0, 0, 0, 0);
    chk({o_spm.word, o_spm.addr}, {16'h005d, 16'h0008});
  endtask
  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    t_shift();
    t_flags();
    t_io();
    t_mem();
    t_ctrl();
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule // bmx_exec_bench

// ### verification/bmx_mem_model.sv
/*
  Behavioural data memory, I/O space, program memory and self-programming unit.
  Assumes the execution block's request timing: pulses one cycle, program byte a cycle later.
*/
`timescale 1ns/1ps
module bmx_mem_model (
  input wire logic i_clk,
  input wire bmx_pkg::bmx_dmem_req_type i_dmem,
  output logic [7:0] o_dmem_rdata,
  input wire logic [5:0] i_io_raddr,
  output logic [7:0] o_io_rdata,
  input wire bmx_pkg::bmx_io_wr_type i_io_wr,
  input wire bmx_pkg::bmx_pmem_req_type i_pmem,
  output logic [7:0] o_pmem_rdata,
  input wire bmx_pkg::bmx_spm_req_type i_spm,
  output logic o_spm_done
);
  logic [7:0] dmem [256];
  logic [7:0] io_mem [64];
  logic [7:0] junk;
  initial begin
    foreach (dmem[i]) dmem[i] = 8'h00;
    foreach (io_mem[i]) io_mem[i] = 8'h00;
    junk = 8'h00;
    o_pmem_rdata = 8'h00;
    o_spm_done = 1'b0;
  end
  // Read data is only valid during a read; otherwise the line keeps changing.
  assign o_dmem_rdata = (i_dmem.en && !i_dmem.we) ? dmem[i_dmem.addr[7:0]] : junk;
  assign o_io_rdata = io_mem[i_io_raddr];
  // Writes land on the edge; the program byte follows its request by one cycle.
  always @(posedge i_clk) begin
    junk <= ~junk;
    if (i_dmem.en && i_dmem.we) dmem[i_dmem.addr[7:0]] <= i_dmem.wdata;
    if (i_io_wr.we) io_mem[i_io_wr.addr] <= i_io_wr.wdata;
    o_pmem_rdata <= i_pmem.en ? (i_pmem.addr[7:0] ^ 8'h5a) : ~o_pmem_rdata;
    o_spm_done <= i_spm.req;
  end
endmodule // bmx_mem_model
